// >>> verilog/asrac_host.sv
/*
 * asrac_host: host controller driving an asynchronous 512K x 8 static memory.
 * Assumes a user request port on i_clk and the memory pins wired directly;
 * read data from the pins are synchronised through two flops.
 */
`timescale 1ns/1ps
module asrac_host #(
   parameter int POWERUP_CYC = asrac_pkg::POWERUP_WAIT_CYC
) (
   input  wire logic                        i_clk,
   input  wire logic                        i_nrst,
   // user request side
   input  wire logic                        i_req,
   input  wire logic                        i_we,
   input  wire logic [asrac_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [asrac_pkg::DATA_W-1:0] i_wdata,
   output logic                             o_ready,
   output logic                             o_rvalid,
   output logic [asrac_pkg::DATA_W-1:0]     o_rdata,
   output logic                             o_wdone,
   // memory pins
   output logic                             o_ce_n,
   output logic                             o_oe_n,
   output logic                             o_we_n,
   output logic [asrac_pkg::ADDR_W-1:0]     o_address_bus,
   output logic [asrac_pkg::DATA_W-1:0]     o_data_bus,
   output logic                             o_data_bus_oe_n,
   input  wire logic [asrac_pkg::DATA_W-1:0] i_data_bus
);
   localparam int CW = asrac_pkg::CNT_W;

   asrac_pkg::asrac_state_t st_q;
   asrac_pkg::asrac_state_t st_d;
   logic [asrac_pkg::ADDR_W-1:0] addr_q;
   logic [asrac_pkg::DATA_W-1:0] wdata_q;
   logic [asrac_pkg::DATA_W-1:0] rdata_q;
   logic [asrac_pkg::DATA_W-1:0] sync1_q;
   logic [asrac_pkg::DATA_W-1:0] sync2_q;
   logic                         ce_n_q;
   logic                         oe_n_q;
   logic                         we_n_q;
   logic                         drv_n_q;
   logic                         rvalid_q;
   logic                         wdone_q;
   logic                         ld;
   logic [CW-1:0]                ld_val;
   logic                         done;
   logic                         pwr_ld_q;

   // ------------------------------------------------------------------
   // timed waits
   // ------------------------------------------------------------------
   asrac_wait_cnt #(.CNT_W(CW)) u_cnt (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_load  (ld),
      .i_value (ld_val),
      .o_done  (done)
   );

   // ------------------------------------------------------------------
   // request acceptance and next state
   // ------------------------------------------------------------------
   wire idle_st   = (st_q == asrac_pkg::ASRAC_ST_IDLE);
   wire take      = idle_st & i_req;
   wire take_rd   = take & ~i_we;
   wire take_wr   = take & i_we;
   // read data sampled after access time plus two sync flops
   wire rd_finish = (st_q == asrac_pkg::ASRAC_ST_RD_WAIT) & done;
   assign o_ready = idle_st;

   always_comb
   begin
      st_d   = st_q;
      ld     = 1'b0;
      ld_val = '0;
      unique case (st_q)
         asrac_pkg::ASRAC_ST_POWERUP:
         begin
            // first cycle loads the wait; done stays low while loading
            // limitation: POWERUP_CYC must fit in the counter width
            ld     = pwr_ld_q;
            ld_val = CW'(POWERUP_CYC);
            if (done)
               st_d = asrac_pkg::ASRAC_ST_IDLE;
         end
         asrac_pkg::ASRAC_ST_IDLE:
            if (take_rd)
            begin
               st_d   = asrac_pkg::ASRAC_ST_RD_SEL;
               ld     = 1'b1;
               ld_val = CW'(asrac_pkg::READ_ACCESS_CYC + 2);
            end
            else if (take_wr)
               st_d = asrac_pkg::ASRAC_ST_WR_SET;
         asrac_pkg::ASRAC_ST_RD_SEL:
            st_d = asrac_pkg::ASRAC_ST_RD_WAIT;
         asrac_pkg::ASRAC_ST_RD_WAIT:
            if (done)
               st_d = asrac_pkg::ASRAC_ST_IDLE;
         asrac_pkg::ASRAC_ST_WR_SET:
         begin
            // output enable already high, wait for memory to float the bus
            st_d   = asrac_pkg::ASRAC_ST_WR_PULS;
            ld     = 1'b1;
            ld_val = CW'(asrac_pkg::BUS_RELEASE_CYC + asrac_pkg::WE_PULSE_CYC);
         end
         asrac_pkg::ASRAC_ST_WR_PULS:
            if (done)
               st_d = asrac_pkg::ASRAC_ST_WR_END;
         asrac_pkg::ASRAC_ST_WR_END:
            st_d = asrac_pkg::ASRAC_ST_IDLE;
         default:
            st_d = asrac_pkg::ASRAC_ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------------
   // state and power-up wait
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         st_q <= asrac_pkg::ASRAC_ST_POWERUP;
      else
         st_q <= st_d;
   end

   // first cycle after reset loads the power-up count
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         pwr_ld_q <= 1'b1;
      else
         pwr_ld_q <= 1'b0;
   end

   // ------------------------------------------------------------------
   // pin drive: address and data latched at acceptance, held to the end
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         addr_q  <= asrac_pkg::ADDR_RST;
         wdata_q <= asrac_pkg::DATA_RST;
      end
      else if (take)
      begin
         addr_q  <= i_addr;
         wdata_q <= i_wdata;
      end
   end

   // strobes: one flop each so pins are glitch free
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         ce_n_q  <= 1'b1;
         oe_n_q  <= 1'b1;
         we_n_q  <= 1'b1;
         drv_n_q <= 1'b1;
      end
      else
      begin
         // select falls one cycle after address is set up
         ce_n_q  <= ~(st_d == asrac_pkg::ASRAC_ST_RD_WAIT || st_d == asrac_pkg::ASRAC_ST_WR_PULS);
         oe_n_q  <= ~(st_d == asrac_pkg::ASRAC_ST_RD_WAIT);
         // strobe never low in a read; both strobes rise together at end
         we_n_q  <= ~(st_d == asrac_pkg::ASRAC_ST_WR_PULS);
         // data driven from the write pulse until one cycle after strobes rise
         drv_n_q <= ~(st_d == asrac_pkg::ASRAC_ST_WR_PULS || st_d == asrac_pkg::ASRAC_ST_WR_END);
      end
   end

   // ------------------------------------------------------------------
   // read data capture through two-flop synchroniser
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sync1_q  <= asrac_pkg::DATA_RST;
         sync2_q  <= asrac_pkg::DATA_RST;
         rdata_q  <= asrac_pkg::DATA_RST;
         rvalid_q <= 1'b0;
         wdone_q  <= 1'b0;
      end
      else
      begin
         sync1_q  <= i_data_bus;
         sync2_q  <= sync1_q;
         rvalid_q <= rd_finish;
         wdone_q  <= (st_q == asrac_pkg::ASRAC_ST_WR_END);
         if (rd_finish)
            rdata_q <= sync2_q;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign o_ce_n          = ce_n_q;
   assign o_oe_n          = oe_n_q;
   assign o_we_n          = we_n_q;
   assign o_address_bus   = addr_q;
   assign o_data_bus      = wdata_q;
   assign o_data_bus_oe_n = drv_n_q;
   assign o_rdata         = rdata_q;
   assign o_rvalid        = rvalid_q;
   assign o_wdone         = wdone_q;
endmodule // asrac_host

// >>> verilog/asrac_pkg.sv
/*
 * asrac_pkg: constants shared by the asynchronous static memory host controller.
 * Assumes a 125 MHz system clock and a 512K x 8 asynchronous memory on the pins.
 */
package asrac_pkg;
   // ------------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------------
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_PS      = 8000;
   localparam int POWERUP_WAIT_US    = 100;
   // least time rounds up to whole cycles
   localparam int POWERUP_WAIT_CYC   = (POWERUP_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // strobe low time and gaps, in cycles (8 ns each)
   localparam int WE_PULSE_NS        = 8;
   localparam int WE_PULSE_CYC       = (WE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int BUS_RELEASE_NS     = 6;
   localparam int BUS_RELEASE_CYC    = (BUS_RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int READ_ACCESS_NS     = 12;
   localparam int READ_ACCESS_CYC    = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W              = 16;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

   // ------------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      ASRAC_ST_POWERUP = 3'b000,
      ASRAC_ST_IDLE    = 3'b001,
      ASRAC_ST_RD_SEL  = 3'b010,
      ASRAC_ST_RD_WAIT = 3'b011,
      ASRAC_ST_WR_SET  = 3'b100,
      ASRAC_ST_WR_PULS = 3'b101,
      ASRAC_ST_WR_END  = 3'b110
   } asrac_state_t;
endpackage

// >>> verilog/asrac_wait_cnt.sv
/*
 * asrac_wait_cnt: loadable down counter used for all timed waits.
 * Assumes a single clock domain; load wins over counting.
 */
`timescale 1ns/1ps
module asrac_wait_cnt #(
   parameter int CNT_W = 16
) (
   input  wire logic             i_clk,
   input  wire logic             i_nrst,
   input  wire logic             i_load,
   input  wire logic [CNT_W-1:0] i_value,
   output logic                  o_done
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   wire              zero = (cnt_q == '0);

   // ------------------------------------------------------------------
   // counter
   // ------------------------------------------------------------------
   assign cnt_d  = i_load ? i_value : (zero ? cnt_q : cnt_q - 1'b1);
   assign o_done = zero & ~i_load;

   // count holds at zero until reloaded
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
endmodule // asrac_wait_cnt

// >>> verification/asrac_host_props.sv
/* asrac_host_props: concurrent checks on the host pins and user handshake.
   assumes it is bound into asrac_host; one clock, async active-low reset. */
`timescale 1ns/1ps
module asrac_host_props #(
   parameter int POWERUP_CYC = 4
) (
   input wire logic                         i_clk,
   input wire logic                         i_nrst,
   input wire logic                         o_ready,
   input wire logic                         o_rvalid,
   input wire logic                         o_wdone,
   input wire logic                         o_ce_n,
   input wire logic                         o_oe_n,
   input wire logic                         o_we_n,
   input wire logic [asrac_pkg::ADDR_W-1:0] o_address_bus,
   input wire logic [asrac_pkg::DATA_W-1:0] o_data_bus,
   input wire logic                         o_data_bus_oe_n
);
   logic [15:0] up_q;
   // --------------------------------------------------------------
   // cycles since reset release, saturating so it never wraps
   // --------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst)
      if (!i_nrst)
         up_q <= 16'h0000;
      else if (up_q != 16'hffff)
         up_q <= up_q + 16'h0001;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   AST_WR_START: assert property ($fell(o_we_n) |-> !o_ce_n)
      else $error("write strobe fell while deselected");
   AST_WR_DATA: assert property (!o_ce_n && !o_we_n |-> !o_data_bus_oe_n && $stable(o_data_bus))
      else $error("write data not driven steady in write window");
   AST_WR_HOLD: assert property ($rose(o_we_n) |-> !o_data_bus_oe_n && $stable(o_data_bus))
      else $error("write data released at terminating edge");
   AST_WR_TOGETHER: assert property ($rose(o_we_n) |-> $rose(o_ce_n))
      else $error("select and strobe did not rise together");
   AST_NO_CLASH: assert property (!o_data_bus_oe_n |-> o_oe_n)
      else $error("host drives data while memory outputs enabled");
   AST_RD_WE_HIGH: assert property (!o_oe_n |-> o_we_n [*2])
      else $error("write strobe low during read");
   AST_ADDR_FIRST: assert property (!o_ce_n |-> $stable(o_address_bus))
      else $error("address moved while selected");
   AST_POWERUP: assert property (o_ready |-> up_q >= POWERUP_CYC)
      else $error("ready before power-up wait");
   AST_RD_ANSWER: assert property ($fell(o_oe_n) |-> ##[1:8] o_rvalid)
      else $error("no read answer");
   AST_WR_ANSWER: assert property ($fell(o_we_n) |-> ##[1:8] o_wdone)
      else $error("no write answer");
endmodule // asrac_host_props
bind asrac_host asrac_host_props #(.POWERUP_CYC(POWERUP_CYC)) u_props (.i_clk(i_clk), .i_nrst(i_nrst),
   .o_ready(o_ready), .o_rvalid(o_rvalid), .o_wdone(o_wdone), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
   .o_we_n(o_we_n), .o_address_bus(o_address_bus), .o_data_bus(o_data_bus), .o_data_bus_oe_n(o_data_bus_oe_n));

// >>> verification/asrac_sram_model.sv
/* asrac_sram_model: behavioural 512K x 8 asynchronous static memory.
   assumes the bench resolves the shared data bus; no clock, no reset. */
`timescale 1ns/1ps
module asrac_sram_model #(
   parameter int RD_DLY = 10
) (
   input  wire logic        i_ce_n,
   input  wire logic        i_oe_n,
   input  wire logic        i_we_n,
   input  wire logic [18:0] i_addr,
   input  wire logic [7:0]  i_data,
   output logic      [7:0]  o_data
);
   logic [7:0] mem [logic [18:0]];
   logic [7:0] last = 8'h00;
   logic       wr_act = 1'b0;
   wire        wr_idle = i_ce_n | i_we_n;
   wire        drive   = !i_ce_n && !i_oe_n && i_we_n;
   // write window opens only on the overlap of select and strobe
   always @(negedge wr_idle) wr_act = 1'b1;
   // first strobe to rise ends the write and stores the byte
   always @(posedge wr_idle)
   begin
      if (wr_act) mem[i_addr] = i_data;
      wr_act = 1'b0;
   end
   // slow answer on reads; a floating bus shows the inverted last byte
   always @(drive or i_addr)
   begin
      if (drive)
      begin
         last = mem.exists(i_addr) ? mem[i_addr] : 8'h00;
         o_data <= #(RD_DLY) last;
      end
      else
         o_data <= ~last;
   end
endmodule // asrac_sram_model

// >>> verification/async_sram_access_control_tb.sv
/* async_sram_access_control_tb: random and corner traffic through the host.
   assumes asrac_host, the memory model and the bound checker. */
`timescale 1ns/1ps
module async_sram_access_control_tb;
   localparam int PU = 4;
   logic        i_clk = 1'b0, i_nrst = 1'b0, i_req = 1'b0, i_we = 1'b0;
   logic [18:0] i_addr = 19'h00000, o_address_bus, a;
   logic [7:0]  i_wdata = 8'h00, o_rdata, o_data_bus, mem_out, bus;
   logic        o_ready, o_rvalid, o_wdone, o_ce_n, o_oe_n, o_we_n, o_data_bus_oe_n;
   logic [31:0] seed = 32'hd0728d6f, r;
   logic [7:0]  shadow [logic [18:0]];
   int          failures = 0, n_compared = 0, k;
   logic        abort = 1'b0;
   always #4 i_clk = ~i_clk;
   // host wins the bus only while it drives it
   assign bus = o_data_bus_oe_n ? mem_out : o_data_bus;
   asrac_host #(.POWERUP_CYC(PU)) uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req), .i_we(i_we),
      .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
      .o_wdone(o_wdone), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_address_bus(o_address_bus),
      .o_data_bus(o_data_bus), .o_data_bus_oe_n(o_data_bus_oe_n), .i_data_bus(bus));
   asrac_sram_model #(.RD_DLY(10)) u_mem (.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
      .i_addr(o_address_bus), .i_data(bus), .o_data(mem_out));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // unwritten locations read back as zero in the model
   function automatic logic [7:0] exp_rd(input logic [18:0] ad);
      return shadow.exists(ad) ? shadow[ad] : 8'h00;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // bounded wait for ready after reset, counted in cycles
   task automatic powerup();
      for (k = 0; k < 100 && o_ready !== 1'b1; k++) @(negedge i_clk);
      check("ready after wait", o_ready, 1'b1);
      check("powerup wait", k >= PU, 1);
      check("idle pins", {o_ce_n, o_oe_n, o_we_n, o_data_bus_oe_n}, 4'hf);
      $display("test powerup done");
   endtask
   // one request held until taken, then wait for its answer
   task automatic op(input logic we, input logic [18:0] ad, input logic [7:0] d);
      // after an answer timeout the remaining op calls are skipped on the way to the report
      if (abort) return;
      i_we = we;
      i_addr = ad;
      i_wdata = d;
      i_req = 1'b1;
      for (k = 0; k < 60 && o_ready !== 1'b1; k++) @(negedge i_clk);
      @(negedge i_clk);
      i_req = 1'b0;
      for (k = 0; k < 60 && (we ? o_wdone : o_rvalid) !== 1'b1; k++) @(negedge i_clk);
      if (k == 60)
      begin
         failures++;
         abort = 1'b1;
         return;
      end
      if (we) shadow[ad] = d;
      else check("read data", o_rdata, exp_rd(ad));
   endtask
   initial
   begin
      repeat (3) @(negedge i_clk);
      i_nrst = 1'b1;
      powerup();
      // corner addresses and data, then back-to-back read-after-write
      op(1'b1, 19'h00000, 8'hff);
      op(1'b1, 19'h7ffff, 8'h00);
      op(1'b1, 19'h2aaaa, 8'ha5);
      op(1'b0, 19'h00000, 8'h00);
      op(1'b0, 19'h7ffff, 8'h00);
      op(1'b0, 19'h2aaaa, 8'h00);
      op(1'b1, 19'h2aaaa, 8'h5a);
      op(1'b0, 19'h2aaaa, 8'h00);
      $display("test corners done");
      for (int n = 0; n < 60; n++)
      begin
         r = xs();
         op(r[31], r[18:0] & 19'h7003f, r[26:19]);
      end
      $display("test random done");
      // reset in the middle of a write, then the wait applies again
      a = 19'h40000;
      i_we = 1'b1;
      i_addr = a;
      i_req = 1'b1;
      repeat (3) @(negedge i_clk);
      i_nrst = 1'b0;
      i_req = 1'b0;
      @(negedge i_clk);
      check("reset pins", {o_ce_n, o_oe_n, o_we_n, o_data_bus_oe_n, o_ready}, 5'h1e);
      i_nrst = 1'b1;
      powerup();
      op(1'b0, 19'h00000, 8'h00);
      $display("test midrun reset done");
      wrap_up();
   end
endmodule // async_sram_access_control_tb
